// *** inc/wpc_pkg.sv ***
// Package of constants and types for the watchpoint pair coupling block
// What this block does
// - Chained unit 0 matches only after latched unit 1
// - Address plus control 4..0, masked equivalence, all ones
// - Data plus control 7..5, same masked equivalence
// - Link latch loads data result during address match
// - Unit 1 link latch feeds unit 0 link input
// - Unit 1 span output feeds unit 0 span input
// - Ranges are aligned power-of-two regions via mask
// - Disabled unit still spans but never breaks
// - Unit 0 expecting span low breaks outside unit 1
// - External conditions sampled on falling clock edge
// - Break request must stay clean during live reprogramming
// - Debug control and status accessible at any time
// - Unit holds address, data, control values and masks
// - Control bus mixes core, other unit, external bits
package wpc_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int WPC_UNITS = 2;
  localparam int WPC_AW = 32;
  localparam int WPC_DW = 32;
  localparam int WPC_CW = 10;
  localparam int WPC_ADR_W = 8;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] WPC_UNIT_STRIDE = 8'h20;
  localparam logic [7:0] WPC_OFF_AV = 8'h00;
  localparam logic [7:0] WPC_OFF_AM = 8'h04;
  localparam logic [7:0] WPC_OFF_DV = 8'h08;
  localparam logic [7:0] WPC_OFF_DM = 8'h0c;
  localparam logic [7:0] WPC_OFF_CV = 8'h10;
  localparam logic [7:0] WPC_OFF_CM = 8'h14;
  localparam logic [7:0] WPC_OFF_STAT = 8'h40;
  localparam logic [7:0] WPC_OFF_IMASK = 8'h44;
  localparam logic [7:0] WPC_OFF_STATE = 8'h48;

  // ----------------------------------------------------------------
  // Control bus bit positions and control value fields
  // ----------------------------------------------------------------
  localparam int WPC_C_EXT = 5;
  localparam int WPC_C_LINK = 6;
  localparam int WPC_C_SPAN = 7;
  localparam int WPC_CV_ENABLE = 8;
  localparam int WPC_CV_W = 9;
  localparam int WPC_CM_W = 8;

  // ----------------------------------------------------------------
  // Status bits and reset values
  // ----------------------------------------------------------------
  localparam int WPC_ST_W = 3;
  localparam int WPC_ST_BREAK = 0;
  localparam int WPC_ST_LINK = 1;
  localparam int WPC_ST_SPAN = 2;
  localparam logic [31:0] WPC_RST_WORD = 32'h0000_0000;
  localparam logic [WPC_CV_W-1:0] WPC_RST_CV = 9'h000;
  localparam logic [WPC_CM_W-1:0] WPC_RST_CM = 8'h00;
  localparam logic [WPC_ST_W-1:0] WPC_RST_ST = 3'h0;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [WPC_AW-1:0] addr;
    logic [WPC_DW-1:0] data;
    logic [4:0] ctrl;
    logic [1:0] aux;
  } wpc_core_bus_type;

  typedef struct packed {
    logic [WPC_AW-1:0] address_value;
    logic [WPC_AW-1:0] address_mask;
    logic [WPC_DW-1:0] data_value;
    logic [WPC_DW-1:0] data_mask;
    logic [WPC_CV_W-1:0] control_value;
    logic [WPC_CM_W-1:0] control_mask;
  } wpc_unit_cfg_type;

endpackage : wpc_pkg

// *** design/wpc_unit.sv ***
// One watchpoint comparator unit with its link latch
`timescale 1ns/1ps
module wpc_unit
  import wpc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // Programming and observed buses
  input wpc_unit_cfg_type cfg_i,
  input wpc_core_bus_type bus_i,
  input wire logic [WPC_CW-1:0] ctrl_i,
  // Results
  output logic link_output_o,
  output logic span_output_o,
  output logic trigger_o,
  output logic addr_hit_o
);

  // ----------------------------------------------------------------
  // Comparators
  // ----------------------------------------------------------------
  logic [WPC_AW+4:0] addr_eq;
  logic [WPC_DW+2:0] data_eq;
  logic addr_hit;
  logic data_hit;
  logic link_r;

  // Masked equivalence; mask ones make a bit a match
  assign addr_eq = ~({cfg_i.address_value, cfg_i.control_value[4:0]} ^ {bus_i.addr, ctrl_i[4:0]})
                   | {cfg_i.address_mask, cfg_i.control_mask[4:0]};
  assign addr_hit = &addr_eq;
  // Data side over data bus and control 7..5
  assign data_eq = ~({cfg_i.data_value, cfg_i.control_value[7:5]} ^ {bus_i.data, ctrl_i[7:5]})
                   | {cfg_i.data_mask, cfg_i.control_mask[7:5]};
  assign data_hit = &data_eq;

  // Span follows the match regardless of enable
  assign span_output_o = addr_hit & data_hit;
  // Only an enabled unit raises a trigger
  assign trigger_o = addr_hit & data_hit & cfg_i.control_value[WPC_CV_ENABLE];
  assign addr_hit_o = addr_hit;
  assign link_output_o = link_r;

  // Link latch written only while the address side matches
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      link_r <= 1'b0;
    end else if (addr_hit) begin
      link_r <= data_hit;
    end
  end

endmodule : wpc_unit

// *** design/wpc_top.sv ***
// Watchpoint pair with chaining, range coupling and Wishbone registers
`timescale 1ns/1ps
module wpc_top
  import wpc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [WPC_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Observed core buses
  input wire logic [WPC_AW-1:0] core_addr_i,
  input wire logic [WPC_DW-1:0] core_data_i,
  input wire logic [4:0] core_ctrl_i,
  input wire logic [1:0] core_aux_i,
  input wire logic [1:0] ext_cond_i,
  // Debug outputs
  output logic break_request_o,
  output logic [WPC_UNITS-1:0] link_output_o,
  output logic [WPC_UNITS-1:0] span_output_o,
  output logic irq_o
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  wpc_unit_cfg_type cfg_r [WPC_UNITS];
  wpc_core_bus_type bus;
  logic [WPC_CW-1:0] ctrl_bus [WPC_UNITS];
  logic [WPC_UNITS-1:0] link_w;
  logic [WPC_UNITS-1:0] span_w;
  logic [WPC_UNITS-1:0] trig_w;
  logic [WPC_UNITS-1:0] ahit_w;
  logic [1:0] ext_r;
  logic break_r;
  logic break_nxt;
  logic link1_d_r;
  logic span1_d_r;
  logic ack_r;
  logic [31:0] rdat_r;
  logic [31:0] rdat_nxt;
  logic [WPC_ST_W-1:0] stat_r;
  logic [WPC_ST_W-1:0] stat_nxt;
  logic [WPC_ST_W-1:0] imask_r;
  logic [WPC_ST_W-1:0] events;
  logic [WPC_ST_W-1:0] clr_bits;
  logic req;
  logic wr_en;
  logic [WPC_UNITS-1:0] unit_sel;
  logic [7:0] fld_off;
  logic [WPC_UNITS-1:0] wr_av;
  logic [WPC_UNITS-1:0] wr_am;
  logic [WPC_UNITS-1:0] wr_dv;
  logic [WPC_UNITS-1:0] wr_dm;
  logic [WPC_UNITS-1:0] wr_cv;
  logic [WPC_UNITS-1:0] wr_cm;
  logic wr_stat;
  logic wr_imask;

  // ----------------------------------------------------------------
  // Byte lane merge for partial writes
  // ----------------------------------------------------------------
  function automatic logic [31:0] wpc_merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                            input logic [3:0] sel);
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
    return res;
  endfunction : wpc_merge

  // ----------------------------------------------------------------
  // External condition sampling
  // ----------------------------------------------------------------
  // Captured on the falling edge so they settle before the next compare
  always_ff @(negedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ext_r <= 2'h0;
    end else begin
      ext_r <= ext_cond_i;
    end
  end

  // ----------------------------------------------------------------
  // Control buses and units
  // ----------------------------------------------------------------
  // Observed core bus bundle
  assign bus.addr = core_addr_i;
  assign bus.data = core_data_i;
  assign bus.ctrl = core_ctrl_i;
  assign bus.aux = core_aux_i;

  // Unit 0 sees unit 1 link latch and span; unit 1 has no partner above it
  assign ctrl_bus[0] = {core_aux_i, span_w[1], link_w[1], ext_r[0], core_ctrl_i};
  assign ctrl_bus[1] = {core_aux_i, 1'b0, 1'b0, ext_r[1], core_ctrl_i};

  // Comparator units, one per slot
  for (genvar u = 0; u < WPC_UNITS; u++) begin : g_unit
    wpc_unit u_unit (
      .sys_clk_i(sys_clk_i),
      .reset_n_i(reset_n_i),
      .cfg_i(cfg_r[u]),
      .bus_i(bus),
      .ctrl_i(ctrl_bus[u]),
      .link_output_o(link_w[u]),
      .span_output_o(span_w[u]),
      .trigger_o(trig_w[u]),
      .addr_hit_o(ahit_w[u])
    );
  end

  assign link_output_o = link_w;
  assign span_output_o = span_w;

  // ----------------------------------------------------------------
  // Break request
  // ----------------------------------------------------------------
  // Chained and range breaks fall out of the unit 0 control compare
  assign break_nxt = |trig_w;

  // Registered so a mid-run reprogram cannot glitch the output
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      break_r <= 1'b0;
    end else begin
      break_r <= break_nxt;
    end
  end

  assign break_request_o = break_r;

  // ----------------------------------------------------------------
  // Event edges for the status register
  // ----------------------------------------------------------------
  // Delayed copies of unit 1 outputs for edge detection
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      link1_d_r <= 1'b0;
      span1_d_r <= 1'b0;
    end else begin
      link1_d_r <= link_w[1];
      span1_d_r <= span_w[1];
    end
  end

  // Rising edges of break, unit 1 link latch and unit 1 span
  assign events[WPC_ST_BREAK] = break_nxt & ~break_r;
  assign events[WPC_ST_LINK] = link_w[1] & ~link1_d_r;
  assign events[WPC_ST_SPAN] = span_w[1] & ~span1_d_r;

  // ----------------------------------------------------------------
  // Wishbone decode
  // ----------------------------------------------------------------
  // Request and write strobe; commit on the edge that raises ack
  assign req = wb_cyc_i & wb_stb_i & ~ack_r;
  assign wr_en = req & wb_we_i;
  assign fld_off = {3'h0, wb_adr_i[4:0]};

  // Per unit field strobes
  for (genvar u = 0; u < WPC_UNITS; u++) begin : g_dec
    assign unit_sel[u] = (wb_adr_i[7:5] == 3'(u));
    assign wr_av[u] = wr_en & unit_sel[u] & (fld_off == WPC_OFF_AV);
    assign wr_am[u] = wr_en & unit_sel[u] & (fld_off == WPC_OFF_AM);
    assign wr_dv[u] = wr_en & unit_sel[u] & (fld_off == WPC_OFF_DV);
    assign wr_dm[u] = wr_en & unit_sel[u] & (fld_off == WPC_OFF_DM);
    assign wr_cv[u] = wr_en & unit_sel[u] & (fld_off == WPC_OFF_CV);
    assign wr_cm[u] = wr_en & unit_sel[u] & (fld_off == WPC_OFF_CM);
  end

  assign wr_stat = wr_en & (wb_adr_i == WPC_OFF_STAT);
  assign wr_imask = wr_en & (wb_adr_i == WPC_OFF_IMASK);

  // ----------------------------------------------------------------
  // Unit programming registers
  // ----------------------------------------------------------------
  // Values and masks per unit, byte lane writes
  for (genvar u = 0; u < WPC_UNITS; u++) begin : g_cfg
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        cfg_r[u].address_value <= WPC_RST_WORD;
        cfg_r[u].address_mask <= WPC_RST_WORD;
        cfg_r[u].data_value <= WPC_RST_WORD;
        cfg_r[u].data_mask <= WPC_RST_WORD;
        cfg_r[u].control_value <= WPC_RST_CV;
        cfg_r[u].control_mask <= WPC_RST_CM;
      end else begin
        if (wr_av[u]) begin
          cfg_r[u].address_value <= wpc_merge(cfg_r[u].address_value, wb_dat_i, wb_sel_i);
        end
        if (wr_am[u]) begin
          cfg_r[u].address_mask <= wpc_merge(cfg_r[u].address_mask, wb_dat_i, wb_sel_i);
        end
        if (wr_dv[u]) begin
          cfg_r[u].data_value <= wpc_merge(cfg_r[u].data_value, wb_dat_i, wb_sel_i);
        end
        if (wr_dm[u]) begin
          cfg_r[u].data_mask <= wpc_merge(cfg_r[u].data_mask, wb_dat_i, wb_sel_i);
        end
        if (wr_cv[u] && wb_sel_i[0]) begin
          cfg_r[u].control_value[7:0] <= wb_dat_i[7:0];
        end
        if (wr_cv[u] && wb_sel_i[1]) begin
          cfg_r[u].control_value[WPC_CV_ENABLE] <= wb_dat_i[WPC_CV_ENABLE];
        end
        if (wr_cm[u] && wb_sel_i[0]) begin
          cfg_r[u].control_mask <= wb_dat_i[WPC_CM_W-1:0];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  // Write one to clear; a same-cycle event wins over the clear
  assign clr_bits = (wr_stat && wb_sel_i[0]) ? wb_dat_i[WPC_ST_W-1:0] : WPC_RST_ST;
  assign stat_nxt = (stat_r & ~clr_bits) | events;

  // Sticky status and its mask
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      stat_r <= WPC_RST_ST;
      imask_r <= WPC_RST_ST;
    end else begin
      stat_r <= stat_nxt;
      if (wr_imask && wb_sel_i[0]) begin
        imask_r <= wb_dat_i[WPC_ST_W-1:0];
      end
    end
  end

  assign irq_o = |(stat_r & imask_r);

  // ----------------------------------------------------------------
  // Read data selection
  // ----------------------------------------------------------------
  // Unmapped addresses read as zero
  always_comb begin
    rdat_nxt = WPC_RST_WORD;
    if (wb_adr_i == WPC_OFF_STAT) begin
      rdat_nxt = {29'h0, stat_r};
    end else if (wb_adr_i == WPC_OFF_IMASK) begin
      rdat_nxt = {29'h0, imask_r};
    end else if (wb_adr_i == WPC_OFF_STATE) begin
      rdat_nxt = {27'h0, span_w, link_w, break_r};
    end else begin
      for (int u = 0; u < WPC_UNITS; u++) begin
        if (unit_sel[u] && fld_off == WPC_OFF_AV) begin
          rdat_nxt = cfg_r[u].address_value;
        end else if (unit_sel[u] && fld_off == WPC_OFF_AM) begin
          rdat_nxt = cfg_r[u].address_mask;
        end else if (unit_sel[u] && fld_off == WPC_OFF_DV) begin
          rdat_nxt = cfg_r[u].data_value;
        end else if (unit_sel[u] && fld_off == WPC_OFF_DM) begin
          rdat_nxt = cfg_r[u].data_mask;
        end else if (unit_sel[u] && fld_off == WPC_OFF_CV) begin
          rdat_nxt = {23'h0, cfg_r[u].control_value};
        end else if (unit_sel[u] && fld_off == WPC_OFF_CM) begin
          rdat_nxt = {24'h0, cfg_r[u].control_mask};
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Wishbone answer
  // ----------------------------------------------------------------
  // One wait state; ack drops the cycle after it is given
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ack_r <= 1'b0;
      rdat_r <= WPC_RST_WORD;
    end else begin
      ack_r <= req;
      if (req) begin
        rdat_r <= rdat_nxt;
      end
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

endmodule : wpc_top

// *** verification/wpc_top_properties.sv ***
// Concurrent checks on the ports of the watchpoint pair block
`timescale 1ns/1ps
module wpc_top_properties
  import wpc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // Register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Debug outputs
  input wire logic break_request_o,
  input wire logic [WPC_UNITS-1:0] link_output_o,
  input wire logic [WPC_UNITS-1:0] span_output_o
);
  // ----------------------------------------------------------------
  // Properties, all on the core event clock
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  // A fresh request is answered in the next cycle
  ack_answer_a: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("request not acknowledged next cycle");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("acknowledge without request");
  // Read data only moves together with an acknowledge
  rdata_hold_a: assert property ($changed(wb_dat_o) |-> wb_ack_o)
    else $error("read data changed outside acknowledge");
  // Registered break: only after a real match one edge before
  break_cause_a: assert property (break_request_o |-> $past(|span_output_o))
    else $error("break request without a match");
  link_one_rise_a: assert property ($rose(link_output_o[1]) |-> $past(span_output_o[1]))
    else $error("unit 1 link set without address and data match");
  link_zero_rise_a: assert property ($rose(link_output_o[0]) |-> $past(span_output_o[0]))
    else $error("unit 0 link set without address and data match");
  link_reset_a: assert property ($rose(reset_n_i) |-> (link_output_o == '0 && !break_request_o))
    else $error("link or break pending after reset");
endmodule : wpc_top_properties

bind wpc_top wpc_top_properties wpc_top_properties_i (
  .sys_clk_i(sys_clk_i),
  .reset_n_i(reset_n_i),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o),
  .break_request_o(break_request_o),
  .link_output_o(link_output_o),
  .span_output_o(span_output_o)
);

// *** verification/wpc_core_model.sv ***
// Behavioural model of the core buses watched by the watchpoint pair
`timescale 1ns/1ps
module wpc_core_model
  import wpc_pkg::*;
(
  // Clock
  input wire logic sys_clk_i,
  // Core buses and external conditions
  output wpc_core_bus_type bus_o,
  output logic [1:0] ext_cond_o
);
  // Parked away from every programmed region so nothing matches while the host programs
  initial begin
    bus_o = '{addr: 32'hffff_fff0, data: 32'h0, ctrl: 5'h1f, aux: 2'h3};
    ext_cond_o = 2'h0;
  end
  // One core cycle, launched just after a rising edge so the falling edge sees it settled
  task automatic present(input logic [31:0] a, input logic [31:0] d, input logic [4:0] c, input logic [1:0] e);
    @(posedge sys_clk_i);
    bus_o <= '{addr: a, data: d, ctrl: c, aux: 2'h3};
    ext_cond_o <= e;
  endtask : present
  // Back to the parked bus before any reprogramming
  task automatic park();
    present(32'hffff_fff0, 32'h0, 5'h1f, 2'h0);
  endtask : park
endmodule : wpc_core_model

// *** verification/wpc_top_bench.sv ***
// Self-checking bench for the watchpoint pair block
`timescale 1ns/1ps
module wpc_top_bench
  import wpc_pkg::*;
;
  logic sys_clk_i;
  logic reset_n_i;
  logic wb_cyc_i;
  logic wb_stb_i;
  logic wb_we_i;
  logic [WPC_ADR_W-1:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic [31:0] rd;
  logic [3:0] lanes;
  logic wb_ack_o;
  logic break_request_o;
  logic irq_o;
  logic [WPC_UNITS-1:0] link_output_o;
  logic [WPC_UNITS-1:0] span_output_o;
  logic [1:0] ext_cond;
  wpc_core_bus_type core_bus;
  int error_cnt;
  int cmp_count;

  wpc_core_model wpc_core_model_i (.sys_clk_i(sys_clk_i), .bus_o(core_bus), .ext_cond_o(ext_cond));

  wpc_top wpc_top_i (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .core_addr_i(core_bus.addr), .core_data_i(core_bus.data), .core_ctrl_i(core_bus.ctrl),
    .core_aux_i(core_bus.aux), .ext_cond_i(ext_cond),
    .break_request_o(break_request_o), .link_output_o(link_output_o),
    .span_output_o(span_output_o), .irq_o(irq_o)
  );

  // Clock of 100 ns
  initial begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Classic single Wishbone cycle, held until the acknowledge edge
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    @(posedge sys_clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= lanes;
    wb_dat_i <= dat;
    n = 0;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) begin
      error_cnt++;
      wrap_up();
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb

  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    wb(1'b1, adr, dat);
  endtask : wr

  task automatic rdx(input logic [7:0] adr, input logic [31:0] exp);
    wb(1'b0, adr, 32'h0);
    check($sformatf("register %h", adr), rd, exp);
  endtask : rdx

  task automatic rst();
    wpc_core_model_i.park();
    reset_n_i <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
  endtask : rst

  // One core cycle: span in that cycle, then link and break after the next edge
  task automatic step(input logic [31:0] a, input logic [31:0] d, input logic [4:0] c, input logic [1:0] e,
                      input logic [1:0] s, input logic [1:0] l, input logic b);
    wpc_core_model_i.present(a, d, c, e);
    @(negedge sys_clk_i);
    // Let the falling-edge capture of the external inputs settle first
    #10;
    check("span", 32'(span_output_o), 32'(s));
    @(negedge sys_clk_i);
    check("link", 32'(link_output_o), 32'(l));
    check("break", 32'(break_request_o), 32'(b));
  endtask : step

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    reset_n_i = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hf;
    lanes = 4'hf;
    wb_dat_i = 32'h0;
    error_cnt = 0;
    cmp_count = 0;
    rst();
    // Reset values and stored widths of both units
    check("link", 32'(link_output_o), 32'h0);
    for (int u = 0; u < 2; u++) begin
      rdx(8'(u * 32) + WPC_OFF_CV, 32'h0);
      wr(8'(u * 32) + WPC_OFF_CV, '1);
      rdx(8'(u * 32) + WPC_OFF_CV, 32'h1ff);
      wr(8'(u * 32) + WPC_OFF_CM, '1);
      rdx(8'(u * 32) + WPC_OFF_CM, 32'hff);
      wr(8'(u * 32) + WPC_OFF_DM, 32'h1234_5678);
      rdx(8'(u * 32) + WPC_OFF_DM, 32'h1234_5678);
      // Single lane writes keep the other bytes and the enable bit
      lanes = 4'h1;
      wr(8'(u * 32) + WPC_OFF_CV, 32'h0);
      rdx(8'(u * 32) + WPC_OFF_CV, 32'h100);
      wr(8'(u * 32) + WPC_OFF_DM, '1);
      rdx(8'(u * 32) + WPC_OFF_DM, 32'h1234_56ff);
      lanes = 4'hf;
    end
    wr(8'h80, '1);
    rdx(8'h80, 32'h0);
    // Range pair: unit 1 disabled 32-byte hole inside unit 0 256-byte region
    rst();
    wr(8'h24, 32'h1f);
    wr(8'h2c, '1);
    wr(8'h30, 32'h0a);
    wr(8'h34, 32'he0);
    wr(8'h04, 32'hff);
    wr(8'h0c, '1);
    wr(8'h10, 32'h100);
    wr(8'h14, 32'h7f);
    step(32'h10, 32'h0, 5'h0a, 2'h0, 2'b10, 2'b10, 1'b0);
    step(32'h10, 32'h0, 5'h0b, 2'h0, 2'b01, 2'b11, 1'b1);
    step(32'h40, 32'h0, 5'h0a, 2'h0, 2'b01, 2'b11, 1'b1);
    step(32'h100, 32'h0, 5'h0a, 2'h0, 2'b00, 2'b11, 1'b0);
    step(32'hff, 32'h0, 5'h0a, 2'h0, 2'b01, 2'b11, 1'b1);
    step(32'h1f, 32'h0, 5'h0a, 2'h0, 2'b10, 2'b10, 1'b0);
    wpc_core_model_i.park();
    // Sticky status, mask and level interrupt
    rdx(WPC_OFF_STAT, 32'h7);
    check("irq", 32'(irq_o), 32'h0);
    wr(WPC_OFF_IMASK, 32'h1);
    check("irq", 32'(irq_o), 32'h1);
    wr(WPC_OFF_STAT, 32'h1);
    check("irq", 32'(irq_o), 32'h0);
    wr(WPC_OFF_IMASK, 32'h6);
    check("irq", 32'(irq_o), 32'h1);
    wr(WPC_OFF_STAT, 32'h6);
    check("irq", 32'(irq_o), 32'h0);
    rdx(WPC_OFF_STAT, 32'h0);
    wr(WPC_OFF_STATE, '1);
    rdx(WPC_OFF_STATE, 32'h4);
    // Chain: unit 1 latches a data match, unit 0 needs the latched link
    rst();
    wr(8'h20, 32'h1000);
    wr(8'h28, 32'hcafe);
    wr(8'h34, 32'hff);
    wr(8'h00, 32'h2000);
    wr(8'h0c, '1);
    wr(8'h10, 32'h140);
    wr(8'h14, 32'hbf);
    step(32'h2000, 32'h0, 5'h0, 2'h0, 2'b00, 2'b00, 1'b0);
    step(32'h1000, 32'hcafe, 5'h0, 2'h0, 2'b10, 2'b10, 1'b0);
    step(32'h3000, 32'h0, 5'h0, 2'h0, 2'b00, 2'b10, 1'b0);
    step(32'h2000, 32'h0, 5'h0, 2'h0, 2'b01, 2'b11, 1'b1);
    step(32'h1000, 32'h1234, 5'h0, 2'h0, 2'b00, 2'b01, 1'b0);
    step(32'h2000, 32'h0, 5'h0, 2'h0, 2'b00, 2'b00, 1'b0);
    // External condition taken at the falling edge
    rst();
    wr(8'h00, 32'h3000);
    wr(8'h0c, '1);
    wr(8'h10, 32'h120);
    wr(8'h14, 32'hdf);
    wpc_core_model_i.present(32'h3000, 32'h0, 5'h0, 2'b01);
    #10;
    check("span early", 32'(span_output_o), 32'h0);
    @(negedge sys_clk_i);
    #10;
    check("span late", 32'(span_output_o), 32'h1);
    step(32'h3000, 32'h0, 5'h0, 2'b10, 2'b00, 2'b00, 1'b0);
    wrap_up();
  end
endmodule : wpc_top_bench
